// *** dosr_top.sv ***
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Contract
// - Per-channel programmable analogue input filter
// - Input span points within plus/minus 160%
// - Analogue output source chosen by select
// - Analogue output filtered with programmable time
// - Inversion mirrors analogue output range
// - Floor code: 0 mA or 4 mA
// - Scaling factor; DC link full scale 1000 V
// - Codes 0-4: none, ready, run, fault, no-fault
// - Codes 5-8: overheat, external, reference, warning
// - Codes 9-11: reverse, preset speed, at speed
// - Codes 12-14: regulator, frequency limit, terminal control
// - Codes 15-18: thermal, fieldbus bit, speed, torque
// - Codes 19-22: brake, brake inverted, contactor, floor
// - Transistor output polarity bit
// - Transistor output turn-on delay
// - Transistor output turn-off delay
// - Relay one: own select and polarity
// - Relay one turn-on delay
// - Relay one turn-off delay
// - Relay two: own select and polarity
module dosr_top
	import dosr_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
)
(
	// Clock, reset, enable
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic CE_I,
	// Register port
	input wire logic [AW-1:0] ADDR_I,
	input wire logic [DW-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [DW-1:0] RDATA_O,
	// Drive measurements and status
	input wire logic signed [DW-1:0] AIN_ONE_I,
	input wire logic signed [DW-1:0] AIN_TWO_I,
	input wire logic signed [DW-1:0] AOUT_SRC_I [NASRC],
	input wire dosr_status_t STATUS_I,
	// Terminal outputs and span-mapped analogue input values
	output logic TRANSISTOR_OUTPUT_ONE_O,
	output logic RELAY_OUTPUT_ONE_O,
	output logic RELAY_OUTPUT_TWO_O,
	output logic [DW-1:0] AOUT_LEVEL_O,
	output logic signed [DW-1:0] AIN_ONE_VALUE_O,
	output logic signed [DW-1:0] AIN_TWO_VALUE_O
);

	function automatic logic route(input logic [SELW-1:0] sel, input dosr_status_t s);
		logic r;
		r = 1'b0;
		case (sel)
			5'h01: r = s.ready;
			5'h02: r = s.run;
			5'h03: r = s.fault;
			5'h04: r = ~s.fault;
			5'h05: r = s.overheat;
			5'h06: r = s.ext_fault;
			5'h07: r = s.ref_fault;
			5'h08: r = s.warning;
			5'h09: r = s.reversed;
			5'h0A: r = s.preset_speed;
			5'h0B: r = s.at_speed;
			5'h0C: r = s.regulator;
			5'h0D: r = s.freq_superv;
			5'h0E: r = s.io_control;
			5'h0F: r = s.thermal;
			5'h10: r = s.fieldbus_din1;
			5'h11: r = s.speed_below;
			5'h12: r = s.torque_superv;
			5'h13: r = s.brake;
			5'h14: r = ~s.brake;
			5'h15: r = s.contactor;
			5'h16: r = s.direct_floor_arrival;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic signed [DW-1:0] clamp_span(input logic signed [DW-1:0] v);
		logic signed [DW-1:0] r;
		r = v;
		if (v > SPAN_LIMIT)
			r = SPAN_LIMIT;
		else if (v < -SPAN_LIMIT)
			r = -SPAN_LIMIT;
		return r;
	endfunction

	function automatic logic signed [DW-1:0] sat16(input logic signed [31:0] v);
		logic signed [DW-1:0] r;
		r = v[DW-1:0];
		if (v > 32'sh00007FFF)
			r = 16'sh7FFF;
		else if (v < -32'sh00008000)
			r = 16'sh8000;
		return r;
	endfunction

	// Maps the span low..high onto zero..full scale
	function automatic logic signed [DW-1:0] span_map(input logic signed [DW-1:0] x,
		input logic signed [DW-1:0] lo, input logic signed [DW-1:0] hi);
		logic signed [31:0] num;
		logic signed [31:0] den;
		num = (32'(x) - 32'(lo)) <<< FS_SHIFT;
		den = 32'(hi) - 32'(lo);
		if (den <= 32'sh0)
			return x;
		return sat16(num / den);
	endfunction

	// Settings
	logic [4:0] filt_time [NFILT];
	logic signed [DW-1:0] span_low [2];
	logic signed [DW-1:0] span_high [2];
	logic [2:0] aout_sel;
	logic aout_invert;
	logic aout_floor;
	logic [DW-1:0] aout_scale;
	logic [SELW-1:0] out_sel [NOUT];
	logic [NOUT-1:0] out_polarity;
	logic [DW-1:0] on_delay [NOUT];
	logic [DW-1:0] off_delay [NOUT];

	// Datapath state
	logic [31:0] tick_cnt;
	logic tick;
	logic signed [DW-1:0] filt_in [NFILT];
	logic signed [DW-1:0] filt_out [NFILT];
	logic [NOUT-1:0] out_state;
	logic [DW-1:0] next_rdata;
	logic signed [31:0] aout_raw;
	logic signed [DW-1:0] aout_norm;
	logic [DW-1:0] next_level;

	wire logic [AW-1:0] idx_sel = (ADDR_I - OFS_SEL_BASE) >> 2;
	wire logic [AW-1:0] idx_on = (ADDR_I - OFS_ON_BASE) >> 2;
	wire logic [AW-1:0] idx_off = (ADDR_I - OFS_OFF_BASE) >> 2;

	// Shared time base for filters and delay timers
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
		begin
			tick_cnt <= 32'h0;
			tick <= 1'b0;
		end
		else if (CE_I)
		begin
			tick <= 1'b0;
			if (tick_cnt >= 32'(TICK_LEN - 1))
			begin
				tick_cnt <= 32'h0;
				tick <= 1'b1;
			end
			else
				tick_cnt <= tick_cnt + 32'h1;
		end
	end

	// Register writes
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
		begin
			for (int i = 0; i < NFILT; i++)
				filt_time[i] <= 5'h0;
			for (int i = 0; i < 2; i++)
			begin
				span_low[i] <= 16'sh0;
				span_high[i] <= RST_SPAN_HIGH;
			end
			aout_sel <= 3'h0;
			aout_invert <= 1'b0;
			aout_floor <= 1'b0;
			aout_scale <= RST_SCALE;
			out_polarity <= '0;
			for (int i = 0; i < NOUT; i++)
			begin
				out_sel[i] <= 5'h0;
				on_delay[i] <= 16'h0;
				off_delay[i] <= 16'h0;
			end
		end
		else if (CE_I && WR_I)
		begin
			case (ADDR_I)
				OFS_AIN1_FILT: filt_time[0] <= WDATA_I[4:0];
				OFS_AIN2_FILT: filt_time[1] <= WDATA_I[4:0];
				OFS_AOUT_FILT: filt_time[2] <= WDATA_I[4:0];
				OFS_AIN1_LOW: span_low[0] <= clamp_span(WDATA_I);
				OFS_AIN1_HIGH: span_high[0] <= clamp_span(WDATA_I);
				OFS_AIN2_LOW: span_low[1] <= clamp_span(WDATA_I);
				OFS_AIN2_HIGH: span_high[1] <= clamp_span(WDATA_I);
				OFS_AOUT_SEL: aout_sel <= WDATA_I[2:0];
				OFS_AOUT_INV: aout_invert <= WDATA_I[0];
				OFS_AOUT_FLOOR: aout_floor <= WDATA_I[0];
				OFS_AOUT_SCALE: aout_scale <= WDATA_I;
				OFS_POLARITY: out_polarity <= WDATA_I[NOUT-1:0];
				default:
				begin
					if (ADDR_I >= OFS_SEL_BASE && ADDR_I < OFS_POLARITY && ADDR_I[1:0] == 2'h0)
						out_sel[idx_sel[1:0]] <= WDATA_I[SELW-1:0];
					if (ADDR_I >= OFS_ON_BASE && ADDR_I < OFS_OFF_BASE && ADDR_I[1:0] == 2'h0)
						on_delay[idx_on[1:0]] <= WDATA_I;
					if (ADDR_I >= OFS_OFF_BASE && ADDR_I < OFS_STATUS && ADDR_I[1:0] == 2'h0)
						off_delay[idx_off[1:0]] <= WDATA_I;
				end
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		next_rdata = 16'h0;
		case (ADDR_I)
			OFS_AIN1_FILT: next_rdata = {11'h0, filt_time[0]};
			OFS_AIN2_FILT: next_rdata = {11'h0, filt_time[1]};
			OFS_AOUT_FILT: next_rdata = {11'h0, filt_time[2]};
			OFS_AIN1_LOW: next_rdata = span_low[0];
			OFS_AIN1_HIGH: next_rdata = span_high[0];
			OFS_AIN2_LOW: next_rdata = span_low[1];
			OFS_AIN2_HIGH: next_rdata = span_high[1];
			OFS_AOUT_SEL: next_rdata = {13'h0, aout_sel};
			OFS_AOUT_INV: next_rdata = {15'h0, aout_invert};
			OFS_AOUT_FLOOR: next_rdata = {15'h0, aout_floor};
			OFS_AOUT_SCALE: next_rdata = aout_scale;
			OFS_POLARITY: next_rdata = {13'h0, out_polarity};
			OFS_STATUS: next_rdata = {13'h0, out_state};
			OFS_AIN1_VAL: next_rdata = AIN_ONE_VALUE_O;
			OFS_AIN2_VAL: next_rdata = AIN_TWO_VALUE_O;
			OFS_AOUT_VAL: next_rdata = AOUT_LEVEL_O;
			default:
			begin
				if (ADDR_I >= OFS_SEL_BASE && ADDR_I < OFS_POLARITY && ADDR_I[1:0] == 2'h0)
					next_rdata = {11'h0, out_sel[idx_sel[1:0]]};
				if (ADDR_I >= OFS_ON_BASE && ADDR_I < OFS_OFF_BASE && ADDR_I[1:0] == 2'h0)
					next_rdata = on_delay[idx_on[1:0]];
				if (ADDR_I >= OFS_OFF_BASE && ADDR_I < OFS_STATUS && ADDR_I[1:0] == 2'h0)
					next_rdata = off_delay[idx_off[1:0]];
			end
		endcase
	end

	// Read data stands for exactly one cycle after the strobe
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
			RDATA_O <= 16'h0;
		else if (CE_I)
			RDATA_O <= RD_I ? next_rdata : 16'h0;
	end

	// Analogue output source and scaling ahead of its filter
	always_comb
	begin
		aout_raw = 32'(AOUT_SRC_I[aout_sel]);
		if (aout_sel == ASRC_DC_LINK)
			aout_raw = (aout_raw <<< FS_SHIFT) / $signed(32'(DC_LINK_FULL_V));
		aout_raw = aout_raw * $signed(32'(aout_scale)) / $signed(32'(SCALE_UNIT));
	end

	assign filt_in[0] = AIN_ONE_I;
	assign filt_in[1] = AIN_TWO_I;
	assign filt_in[2] = sat16(aout_raw);

	// First-order filters: y += (x - y) / 2^k per tick, k=0 passes through
	generate
		for (genvar f = 0; f < NFILT; f++)
		begin : g_filt
			logic signed [31:0] acc;
			logic signed [32:0] diff;
			logic [4:0] k;
			assign k = (filt_time[f] > FILT_SHIFT_MAX) ? FILT_SHIFT_MAX : filt_time[f];
			assign diff = {filt_in[f][DW-1], filt_in[f], 16'h0} - {acc[31], acc};
			assign filt_out[f] = acc[31:16];
			always_ff @(posedge CLK_I)
			begin
				if (!RESETN_I)
					acc <= 32'sh0;
				else if (CE_I && (tick || k == 5'h0))
					acc <= acc + 32'(diff >>> k);
			end
		end
	endgenerate

	// Span mapping after the input filter
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
		begin
			AIN_ONE_VALUE_O <= 16'sh0;
			AIN_TWO_VALUE_O <= 16'sh0;
		end
		else if (CE_I)
		begin
			AIN_ONE_VALUE_O <= span_map(filt_out[0], span_low[0], span_high[0]);
			AIN_TWO_VALUE_O <= span_map(filt_out[1], span_low[1], span_high[1]);
		end
	end

	// Inversion, floor and conversion to output level
	always_comb
	begin
		aout_norm = filt_out[2];
		if (aout_norm < 16'sh0)
			aout_norm = 16'sh0;
		else if (aout_norm > FULL_SCALE)
			aout_norm = FULL_SCALE;
		if (aout_invert)
			aout_norm = FULL_SCALE - aout_norm;
		if (aout_floor)
			next_level = DAC_FLOOR_4MA + DW'((32'(aout_norm) * 32'(DAC_FULL - DAC_FLOOR_4MA)) >>> FS_SHIFT);
		else
			next_level = DW'((32'(aout_norm) * 32'(DAC_FULL)) >>> FS_SHIFT);
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
			AOUT_LEVEL_O <= 16'h0;
		else if (CE_I)
			AOUT_LEVEL_O <= next_level;
	end

	// Discrete outputs: route, polarity, then on/off delay
	generate
		for (genvar o = 0; o < NOUT; o++)
		begin : g_out
			logic want;
			logic [DW-1:0] cnt;
			dosr_dly_t state;
			assign want = route(out_sel[o], STATUS_I) ^ out_polarity[o];
			always_ff @(posedge CLK_I)
			begin
				if (!RESETN_I)
				begin
					state <= DLY_IDLE;
					cnt <= 16'h0;
					out_state[o] <= 1'b0;
				end
				else if (CE_I)
				begin
					case (state)
						DLY_IDLE:
						begin
							cnt <= 16'h0;
							if (want != out_state[o])
								state <= DLY_WAIT;
						end
						DLY_WAIT:
						begin
							if (want == out_state[o])
							begin
								state <= DLY_IDLE;
								cnt <= 16'h0;
							end
							else if (cnt >= (want ? on_delay[o] : off_delay[o]))
							begin
								out_state[o] <= want;
								state <= DLY_IDLE;
								cnt <= 16'h0;
							end
							else if (tick)
								cnt <= cnt + 16'h1;
						end
						default: state <= DLY_IDLE;
					endcase
				end
			end
		end
	endgenerate

	// Pin outputs are the delay stage flops themselves
	assign TRANSISTOR_OUTPUT_ONE_O = out_state[0];
	assign RELAY_OUTPUT_ONE_O = out_state[1];
	assign RELAY_OUTPUT_TWO_O = out_state[2];

endmodule

// *** dosr_pkg.sv ***
package dosr_pkg;
	// Data path and bus widths
	localparam int DW = 16;
	localparam int AW = 8;
	localparam int NOUT = 3;
	localparam int NFILT = 3;
	localparam int NASRC = 8;
	localparam int SELW = 5;
	// Normalised full scale: 16'h4000 is 100 percent of the reference
	localparam logic signed [DW-1:0] FULL_SCALE = 16'sh4000;
	localparam int FS_SHIFT = 14;
	// 160 percent of full scale
	localparam logic signed [DW-1:0] SPAN_LIMIT = 16'sh6666;
	localparam logic [DW-1:0] SCALE_UNIT = 16'h0064;
	localparam logic [DW-1:0] DC_LINK_FULL_V = 16'h03E8;
	// Output level: 16'hFFFF is 20 mA, 16'h3333 is 4 mA
	localparam logic [DW-1:0] DAC_FULL = 16'hFFFF;
	localparam logic [DW-1:0] DAC_FLOOR_4MA = 16'h3333;
	localparam logic [4:0] FILT_SHIFT_MAX = 5'h0F;
	// Timer tick
	localparam int CLK_MHZ = 200;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
	// Analogue output source codes
	localparam logic [2:0] ASRC_DC_LINK = 3'h7;
	// Register byte offsets
	localparam logic [AW-1:0] OFS_AIN1_FILT = 8'h00;
	localparam logic [AW-1:0] OFS_AIN2_FILT = 8'h04;
	localparam logic [AW-1:0] OFS_AIN1_LOW = 8'h08;
	localparam logic [AW-1:0] OFS_AIN1_HIGH = 8'h0C;
	localparam logic [AW-1:0] OFS_AIN2_LOW = 8'h10;
	localparam logic [AW-1:0] OFS_AIN2_HIGH = 8'h14;
	localparam logic [AW-1:0] OFS_AOUT_SEL = 8'h18;
	localparam logic [AW-1:0] OFS_AOUT_FILT = 8'h1C;
	localparam logic [AW-1:0] OFS_AOUT_INV = 8'h20;
	localparam logic [AW-1:0] OFS_AOUT_FLOOR = 8'h24;
	localparam logic [AW-1:0] OFS_AOUT_SCALE = 8'h28;
	localparam logic [AW-1:0] OFS_SEL_BASE = 8'h2C;
	localparam logic [AW-1:0] OFS_POLARITY = 8'h38;
	localparam logic [AW-1:0] OFS_ON_BASE = 8'h40;
	localparam logic [AW-1:0] OFS_OFF_BASE = 8'h4C;
	localparam logic [AW-1:0] OFS_STATUS = 8'h58;
	localparam logic [AW-1:0] OFS_AIN1_VAL = 8'h5C;
	localparam logic [AW-1:0] OFS_AIN2_VAL = 8'h60;
	localparam logic [AW-1:0] OFS_AOUT_VAL = 8'h64;
	// Reset values
	localparam logic [DW-1:0] RST_SCALE = 16'h0064;
	localparam logic signed [DW-1:0] RST_SPAN_HIGH = 16'sh4000;
	// Drive status carried to the output router
	typedef struct packed {
		logic ready;
		logic run;
		logic fault;
		logic overheat;
		logic ext_fault;
		logic ref_fault;
		logic warning;
		logic reversed;
		logic preset_speed;
		logic at_speed;
		logic regulator;
		logic freq_superv;
		logic io_control;
		logic thermal;
		logic fieldbus_din1;
		logic speed_below;
		logic torque_superv;
		logic brake;
		logic contactor;
		logic direct_floor_arrival;
	} dosr_status_t;
	typedef enum logic [1:0] {DLY_IDLE, DLY_WAIT} dosr_dly_t;
endpackage

// *** dosr_monitor.sv ***
`timescale 1ns/1ps
module dosr_monitor
	import dosr_pkg::*;
(
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic CE_I,
	// Register port
	input wire logic [AW-1:0] ADDR_I,
	input wire logic [DW-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [DW-1:0] RDATA_O,
	// Terminal outputs
	input wire logic TRANSISTOR_OUTPUT_ONE_O,
	input wire logic RELAY_OUTPUT_ONE_O,
	input wire logic RELAY_OUTPUT_TWO_O,
	input wire logic [DW-1:0] AOUT_LEVEL_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);
	logic w_take;
	logic r_take;
	assign w_take = CE_I && WR_I;
	assign r_take = CE_I && RD_I;
	// Write then read of one place, back to back
	sequence wr_rd(a);
		w_take && ADDR_I == a ##1 r_take && ADDR_I == a;
	endsequence
	a_rdata_idle: assert property (CE_I && !RD_I |=> RDATA_O == '0)
		else $error("read data not zero outside a read");
	a_unmapped_read: assert property (r_take && ADDR_I > OFS_AOUT_VAL |=> RDATA_O == '0)
		else $error("unmapped read returned data");
	a_reset_clears: assert property (disable iff (1'b0) !RESETN_I && CE_I |=> !TRANSISTOR_OUTPUT_ONE_O
		&& !RELAY_OUTPUT_ONE_O && !RELAY_OUTPUT_TWO_O && AOUT_LEVEL_O == '0 && RDATA_O == '0)
		else $error("outputs not cleared by reset");
	a_scale_readback: assert property (wr_rd(OFS_AOUT_SCALE) |=> RDATA_O == $past(WDATA_I, 2))
		else $error("scale read back wrong");
	a_span_clamp_high: assert property (w_take && ADDR_I == OFS_AIN1_LOW && $signed(WDATA_I) > SPAN_LIMIT
		##1 r_take && ADDR_I == OFS_AIN1_LOW |=> RDATA_O == SPAN_LIMIT)
		else $error("span high clamp wrong");
	a_span_clamp_low: assert property (w_take && ADDR_I == OFS_AIN1_LOW && $signed(WDATA_I) < -SPAN_LIMIT
		##1 r_take && ADDR_I == OFS_AIN1_LOW |=> RDATA_O == 16'h999A)
		else $error("span low clamp wrong");
	a_polarity_readback: assert property (wr_rd(OFS_POLARITY) |=> RDATA_O == ($past(WDATA_I, 2) & 16'h0007))
		else $error("polarity read back wrong");
	a_select_readback: assert property (wr_rd(OFS_SEL_BASE) |=> RDATA_O == ($past(WDATA_I, 2) & 16'h001F))
		else $error("select read back wrong");
	a_floor_readback: assert property (wr_rd(OFS_AOUT_FLOOR) |=> RDATA_O == ($past(WDATA_I, 2) & 16'h0001))
		else $error("floor read back wrong");
	c_tout_on: cover property ($rose(TRANSISTOR_OUTPUT_ONE_O));
	c_relay_two_on: cover property ($rose(RELAY_OUTPUT_TWO_O));
	c_unmapped: cover property (r_take && ADDR_I > OFS_AOUT_VAL);
endmodule

bind dosr_top dosr_monitor u_monitor (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.TRANSISTOR_OUTPUT_ONE_O(TRANSISTOR_OUTPUT_ONE_O), .RELAY_OUTPUT_ONE_O(RELAY_OUTPUT_ONE_O),
	.RELAY_OUTPUT_TWO_O(RELAY_OUTPUT_TWO_O), .AOUT_LEVEL_O(AOUT_LEVEL_O));

// *** dosr_terminal_model.sv ***
`timescale 1ns/1ps
module dosr_terminal_model
	import dosr_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Coils and potentiometers
	input wire logic [2:0] coil_i,
	input wire logic signed [DW-1:0] pot_one_i,
	input wire logic signed [DW-1:0] pot_two_i,
	// Contacts and input wiring
	output logic [2:0] contact_o,
	output logic signed [DW-1:0] ain_one_o,
	output logic signed [DW-1:0] ain_two_o
);
	// Wiring is passive, so the inputs follow the potentiometers at once
	assign ain_one_o = pot_one_i;
	assign ain_two_o = pot_two_i;
	// A contact is never instant: it lags its coil by one cycle
	always_ff @(posedge clk_i)
	begin
		contact_o <= coil_i;
	end
endmodule

// *** drive_output_signal_router_tb_top.sv ***
`timescale 1ns/1ps
module drive_output_signal_router_tb_top;
	import dosr_pkg::*;
	localparam int TL = 4;
	localparam int ASEL [6] = '{0, 3, 0, 0, 7, 0};
	localparam int AINV [6] = '{0, 0, 1, 0, 0, 0};
	localparam int AFL [6] = '{0, 0, 0, 1, 0, 0};
	localparam int ASC [6] = '{100, 100, 100, 100, 100, 200};
	logic clk, resetn, wr, rd, ce;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata, rdata, level;
	logic signed [DW-1:0] ain1, ain2, pot1, pot2, v1, v2;
	logic signed [DW-1:0] src [NASRC];
	dosr_status_t st;
	wire logic [2:0] outs;
	logic [2:0] contact;
	int errors, checks_done;

	dosr_top #(.TICK_LEN(TL)) DUT (.CLK_I(clk), .RESETN_I(resetn), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .AIN_ONE_I(ain1), .AIN_TWO_I(ain2), .AOUT_SRC_I(src),
		.STATUS_I(st), .TRANSISTOR_OUTPUT_ONE_O(outs[0]), .RELAY_OUTPUT_ONE_O(outs[1]),
		.RELAY_OUTPUT_TWO_O(outs[2]), .AOUT_LEVEL_O(level), .AIN_ONE_VALUE_O(v1), .AIN_TWO_VALUE_O(v2));
	dosr_terminal_model PM (.clk_i(clk), .coil_i(outs), .pot_one_i(pot1), .pot_two_i(pot2),
		.contact_o(contact), .ain_one_o(ain1), .ain_two_o(ain2));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task report_and_stop;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Every output is a flop, so a look at the edge sees the value of the cycle just ended
	task settle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Strobe lowered at one edge and raised no sooner than the next
	task wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	// Read data stand for one cycle only: taken at the edge that closes it
	task rreg(input logic [AW-1:0] a, input logic [DW-1:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		chk(rdata, e);
	endtask

	// Write and read of one place back to back, with no gap
	task wrrd(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [DW-1:0] e);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		chk(rdata, e);
	endtask

	task wait_out(input int i, input logic v, output int n);
		n = 0;
		while (outs[i] !== v)
		begin
			settle(1);
			n++;
			if (n > 60)
			begin
				errors++;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, outs[i], v);
				report_and_stop;
			end
		end
	endtask

	function automatic int bit_of(input int c);
		if (c == 0 || c > 22) return 0;
		if (c <= 3) return 20 - c;
		if (c == 4) return 17;
		if (c <= 19) return 21 - c;
		if (c == 20) return 2;
		return 22 - c;
	endfunction

	function automatic logic expect_on(input int c, input logic [19:0] s);
		if (c == 0 || c > 22) return 1'b0;
		if (c == 4 || c == 20) return !s[bit_of(c)];
		return s[bit_of(c)];
	endfunction

	function automatic logic [DW-1:0] aout_exp(input int s, input int inv, input int fl, input int sc);
		int n;
		int f;
		n = s * sc / 100;
		if (n > 16384) n = 16384;
		if (n < 0) n = 0;
		if (inv != 0) n = 16384 - n;
		f = (fl != 0) ? int'(DAC_FLOOR_4MA) : 0;
		return 16'(f + n * (int'(DAC_FULL) - f) / 16384);
	endfunction

	task t_regs;
		rreg(OFS_AOUT_SCALE, RST_SCALE);
		rreg(OFS_AIN1_HIGH, RST_SPAN_HIGH);
		rreg(OFS_SEL_BASE, 16'h0000);
		wrrd(8'hF0, 16'hA5A5, 16'h0000);
		rreg(8'hFC, 16'h0000);
	endtask

	// Walks every code with a lone bit, and with all bits but that one
	task t_select;
		logic [19:0] p [3];
		wrrd(OFS_POLARITY, 16'h0002, 16'h0002);
		for (int c = 0; c < 24; c++)
		begin
			for (int i = 0; i < 3; i++)
				wrrd(OFS_SEL_BASE + 8'(4 * i), 16'(c), 16'(c));
			p[0] = '0;
			p[1] = 20'h1 << bit_of(c);
			p[2] = ~p[1];
			for (int k = 0; k < 3; k++)
			begin
				st <= p[k];
				settle(5);
				for (int i = 0; i < 3; i++)
					chk(16'(contact[i]), 16'(expect_on(c, p[k]) ^ (i == 1)));
			end
		end
	endtask

	task t_delay;
		int n;
		wreg(OFS_POLARITY, 16'h0000);
		for (int i = 0; i < 3; i++)
		begin
			for (int j = 0; j < 3; j++)
				wreg(OFS_SEL_BASE + 8'(4 * j), (i == j) ? 16'h0002 : 16'h0000);
			wreg(OFS_ON_BASE + 8'(4 * i), 16'h0003);
			wreg(OFS_OFF_BASE + 8'(4 * i), 16'h0002);
			st <= '0;
			settle(20);
			n = 0;
			st.run <= 1'b1;
			settle(6);
			st.run <= 1'b0;
			repeat (20)
			begin
				settle(1);
				n += int'(outs[i]);
			end
			chk(16'(n), 16'h0000);
			st.run <= 1'b1;
			wait_out(i, 1'b1, n);
			chk(16'(n > 2 * TL && n <= 3 * TL + 4), 16'h0001);
			st.run <= 1'b0;
			wait_out(i, 1'b0, n);
			chk(16'(n > TL && n <= 2 * TL + 4), 16'h0001);
		end
	endtask

	task t_ain;
		pot1 <= 16'sh1800;
		wrrd(OFS_AIN1_LOW, 16'h7FFF, 16'h6666);
		wrrd(OFS_AIN1_LOW, 16'h8000, 16'h999A);
		wreg(OFS_AIN1_LOW, 16'h1000);
		wreg(OFS_AIN1_HIGH, 16'h3000);
		settle(5);
		chk(v1, 16'h1000);
		wreg(OFS_AIN2_FILT, 16'h0002);
		pot2 <= 16'sh4000;
		settle(15);
		chk(16'(v2 >= 16'sh2000 && v2 <= 16'sh3000), 16'h0001);
		settle(200);
		chk(16'(v2 > 16'sh3F00), 16'h0001);
	endtask

	task t_aout;
		int s;
		for (int k = 0; k < 6; k++)
		begin
			s = (ASEL[k] == 7) ? 500 * 16384 / 1000 : int'(src[ASEL[k]]);
			wreg(OFS_AOUT_SEL, 16'(ASEL[k]));
			wreg(OFS_AOUT_INV, 16'(AINV[k]));
			wrrd(OFS_AOUT_FLOOR, 16'(AFL[k]), 16'(AFL[k]));
			wrrd(OFS_AOUT_SCALE, 16'(ASC[k]), 16'(ASC[k]));
			settle(6);
			chk(level, aout_exp(s, AINV[k], AFL[k], ASC[k]));
		end
		// A slow filter must hold the level near its old value for a while
		wreg(OFS_AOUT_FILT, 16'h0003);
		wreg(OFS_AOUT_SCALE, 16'h0064);
		settle(2);
		chk(16'(level > 16'h7000), 16'h0001);
		settle(300);
		chk(16'(level >= 16'h3FF0 && level <= 16'h4010), 16'h0001);
	endtask

	// With the enable low a write must not land
	task t_freeze;
		ce <= 1'b0;
		wreg(OFS_AOUT_SCALE, 16'h00C8);
		ce <= 1'b1;
		rreg(OFS_AOUT_SCALE, 16'h0064);
	endtask

	initial
	begin
		errors = 0;
		checks_done = 0;
		resetn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		ce = 1'b1;
		addr = '0;
		wdata = '0;
		st = '0;
		pot1 = '0;
		pot2 = '0;
		foreach (src[i]) src[i] = '0;
		src[0] = 16'sh1000;
		src[3] = 16'sh0800;
		src[7] = 16'sh01F4;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_regs;
		t_select;
		t_delay;
		t_ain;
		t_aout;
		t_freeze;
		report_and_stop;
	end
endmodule
